// [bench/gpp_board.sv]
// gpp_board: board circuitry on the port pins
// assumes: bench decides which pins it drives from outside
`timescale 1ns/1ps
module gpp_board
  import gpp_pkg::*;
(
  // clock
  input wire logic mclk,
  // pad side of the port
  input wire gpp_pad_type pad,
  // outside drivers
  input wire logic [GPP_WIDTH-1:0] ext_en,
  input wire logic [GPP_WIDTH-1:0] ext_val,
  // resolved levels
  output logic [GPP_WIDTH-1:0] pin
);
  // --------------------------------------------
  // floating pins wander each cycle
  // --------------------------------------------
  logic flt_q = 1'b0;
  always_ff @(posedge mclk) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < GPP_WIDTH; i++) begin
      if (pad.oe[i]) begin
        pin[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pad.pullup_en[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = flt_q ^ i[0];
      end
    end
  end
endmodule

// [bench/tb_top.sv]
// tb_top: self-checking bench for gpp_port
// assumes: open-drain high nibble, peripheral read on bits 3:2
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top
  import gpp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  gpp_access_type acc = '0;
  logic [7:0] pull = 8'h00;
  logic [7:0] per = 8'h00;
  logic [7:0] ee = 8'h00;
  logic [7:0] ev = 8'h00;
  logic [7:0] pin;
  logic [7:0] rd_v;
  gpp_pad_type pad;
  int err_count = 0;
  int checked = 0;
  gpp_port #(.OPEN_DRAIN(8'hF0), .PERIPH_READ(8'h0C)) dut_u (.mclk(mclk),
    .rst_n(rst_n), .clk_en(en), .acc(acc), .rdata_q(rd_v),
    .pullup_ctl(pull), .periph_out(per), .pin_in(pin), .pad_q(pad));
  gpp_board brd_u (.mclk(mclk), .pad(pad), .ext_en(ee), .ext_val(ev),
    .pin(pin));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // --------------------------------------------
  // cpu access tasks
  // --------------------------------------------
  task automatic wr(input logic d, input logic [7:0] v);
    @(negedge mclk);
    acc.data_wr = ~d;
    acc.dir_wr = d;
    acc.wdata = v;
    @(negedge mclk);
    acc = '0;
  endtask
  task automatic rd(input logic d, output logic [7:0] v);
    repeat (3) @(negedge mclk);
    acc.data_rd = ~d;
    acc.dir_rd = d;
    @(negedge mclk);
    acc = '0;
    v = rd_v;
  endtask
  task automatic conclude;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------------------------------
  // scenarios
  // --------------------------------------------
  task automatic t_input;
    logic [7:0] v;
    `CHK(pad.oe, 8'h00)
    `CHK(pad.pullup_en, 8'hFF)
    ee = 8'h0F;
    ev = 8'hA5;
    rd(0, v);
    `CHK(v, 8'hF5)
    wr(0, 8'h3C);
    `CHK(pad.oe, 8'h00)
    $display("input done");
  endtask
  task automatic t_output;
    logic [7:0] v;
    ee = 8'hF0;
    per = 8'h08;
    wr(1, 8'h0F);
    `CHK(pad.oe, 8'h0F)
    `CHK(pad.out & 8'h0F, 8'h0C)
    `CHK(pad.pullup_en, 8'hF0)
    rd(0, v);
    `CHK(v, 8'hA8)
    $display("output done");
  endtask
  task automatic t_odrain;
    logic [7:0] v;
    ee = 8'h00;
    wr(1, 8'hFF);
    wr(0, 8'h5A);
    `CHK(pad.out, 8'h0A)
    `CHK(pad.oe, 8'hAF)
    `CHK(pad.pullup_en, 8'h00)
    rd(1, v);
    `CHK(v, GPP_DIR_INVALID_READ)
    $display("open-drain done");
  endtask
  task automatic t_rmw;
    logic [7:0] v;
    wr(1, 8'h00);
    ee = 8'hFF;
    ev = 8'h96;
    rd(0, v);
    wr(0, v);
    ee = 8'h00;
    wr(1, 8'hFF);
    `CHK(pad.out, 8'h06)
    `CHK(pad.oe, 8'h6F)
    $display("rmw done");
  endtask
  task automatic t_freeze;
    logic [7:0] v;
    en = 1'b0;
    wr(0, 8'h00);
    `CHK(pad.out, 8'h06)
    `CHK(pad.oe, 8'h6F)
    en = 1'b1;
    rd(0, v);
    `CHK(v, 8'h9A)
    $display("freeze done");
  endtask
  initial begin
    pull = 8'hFF;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_input();
    t_output();
    t_odrain();
    t_rmw();
    t_freeze();
    conclude();
  end
endmodule

// [rtl/gpp_pkg.sv]
// gpp_pkg: constants and carrier types for the general-purpose port block
// assumes: one 8-bit port per instance, cpu access on the system clock
package gpp_pkg;

  localparam int unsigned GPP_WIDTH = 8;
  localparam logic [GPP_WIDTH-1:0] GPP_DIR_RESET = 8'h00;
  localparam logic [GPP_WIDTH-1:0] GPP_LATCH_RESET = 8'h00;
  localparam logic GPP_DIR_IN = 1'h0;
  localparam logic GPP_DIR_OUT = 1'h1;
  localparam logic [GPP_WIDTH-1:0] GPP_DIR_INVALID_READ = 8'h00;

  // cpu access to the port: data register and direction register
  typedef struct packed {
    logic data_wr;
    logic data_rd;
    logic dir_wr;
    logic dir_rd;
    logic [GPP_WIDTH-1:0] wdata;
  } gpp_access_type;

  // pad-side controls for all pins of the port
  typedef struct packed {
    logic [GPP_WIDTH-1:0] out;
    logic [GPP_WIDTH-1:0] oe;
    logic [GPP_WIDTH-1:0] pullup_en;
  } gpp_pad_type;

endpackage

// [rtl/gpp_port.sv]
// gpp_port: one 8-bit i/o port with direction, latch and pull-up control
// assumes: pins arrive asynchronously, cpu strobes are on mclk
//
// Overview of operation
// - pull-up connects only in input mode
// - open-drain pin releases when latch is one
// - each direction register bit selects its own pin's mode
// - input bit reads synchronised pin level
// - input-bit write only updates the latch
// - output bit reads latch or peripheral output
// - output-bit write loads latch, drives pin except where an open-drain bit is written one
// - direction register is write-only, reads invalid
// - all pins input after reset
// - read-modify-write stores what each bit read
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [GPP_WIDTH-1:0] OPEN_DRAIN = 8'h00,
  parameter logic [GPP_WIDTH-1:0] PERIPH_READ = 8'h00
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // cpu access
  input wire gpp_access_type acc,
  output logic [GPP_WIDTH-1:0] rdata_q,
  // pull-up control and peripheral output
  input wire logic [GPP_WIDTH-1:0] pullup_ctl,
  input wire logic [GPP_WIDTH-1:0] periph_out,
  // pins
  input wire logic [GPP_WIDTH-1:0] pin_in,
  output gpp_pad_type pad_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [GPP_WIDTH-1:0] dir_q;
  logic [GPP_WIDTH-1:0] latch_q;
  logic [GPP_WIDTH-1:0] pin_meta_q;
  logic [GPP_WIDTH-1:0] pin_sync_q;
  logic [GPP_WIDTH-1:0] read_view;

  // per-bit value seen by a read of the data register
  function automatic logic [GPP_WIDTH-1:0] port_view(
    input logic [GPP_WIDTH-1:0] dir,
    input logic [GPP_WIDTH-1:0] lat,
    input logic [GPP_WIDTH-1:0] pin,
    input logic [GPP_WIDTH-1:0] per
  );
    logic [GPP_WIDTH-1:0] outv;
    outv = (PERIPH_READ & per) | (~PERIPH_READ & lat);
    return (dir & outv) | (~dir & pin);
  endfunction

  assign read_view = port_view(dir_q, latch_q, pin_sync_q, periph_out);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= GPP_LATCH_RESET;
      pin_sync_q <= GPP_LATCH_RESET;
    end else if (clk_en) begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // direction register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= GPP_DIR_RESET;
    end else if (clk_en && acc.dir_wr) begin
      dir_q <= acc.wdata;
    end
  end

  // ----------------------------------------------------------------
  // port latch
  // ----------------------------------------------------------------
  // latch loads on every write regardless of mode; a read-modify-write
  // arrives as a write of the value the cpu read, so input bits take the
  // pin level and periph-read bits take the peripheral value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= GPP_LATCH_RESET;
    end else if (clk_en && acc.data_wr) begin
      latch_q <= acc.wdata;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= GPP_LATCH_RESET;
    end else if (clk_en) begin
      if (acc.data_rd) begin
        rdata_q <= read_view;
      end else if (acc.dir_rd) begin
        rdata_q <= GPP_DIR_INVALID_READ;
      end
    end
  end

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  logic [GPP_WIDTH-1:0] oe_d;
  logic [GPP_WIDTH-1:0] lat_d;
  logic [GPP_WIDTH-1:0] dir_d;

  always_comb begin
    dir_d = dir_q;
    lat_d = latch_q;
    if (acc.dir_wr) begin
      dir_d = acc.wdata;
    end
    if (acc.data_wr) begin
      lat_d = acc.wdata;
    end
    oe_d = dir_d & ~(OPEN_DRAIN & lat_d);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_q <= '0;
    end else if (clk_en) begin
      pad_q.out <= lat_d & ~OPEN_DRAIN;
      pad_q.oe <= oe_d;
      pad_q.pullup_en <= pullup_ctl & ~dir_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_pullup_input_only: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pad_q.pullup_en & dir_q) == '0)
    else $error("pull-up enabled on output pin");

  chk_open_drain_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pad_q.oe & OPEN_DRAIN & latch_q) == '0)
    else $error("open-drain pin driven while latch high");

  chk_dir_write_mode: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_en && acc.dir_wr |=> dir_q == $past(acc.wdata))
    else $error("direction write not taken");

  chk_read_input_pin: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_en && acc.data_rd |=>
      (rdata_q & ~$past(dir_q)) == ($past(pin_sync_q) & ~$past(dir_q)))
    else $error("input bit read wrong");

  chk_input_no_drive: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pad_q.oe & ~dir_q) == '0)
    else $error("input pin driven");

  chk_read_output_bit: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_en && acc.data_rd |=>
      (rdata_q & $past(dir_q) & ~PERIPH_READ) ==
      ($past(latch_q) & $past(dir_q) & ~PERIPH_READ))
    else $error("output bit read wrong");

  chk_output_drive: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pad_q.oe & ~OPEN_DRAIN) == (dir_q & ~OPEN_DRAIN) &&
    (pad_q.out & dir_q & ~OPEN_DRAIN) == (latch_q & dir_q & ~OPEN_DRAIN))
    else $error("push-pull output not driving latch");

  chk_dir_read_invalid: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_en && acc.dir_rd && !acc.data_rd |=> rdata_q == GPP_DIR_INVALID_READ)
    else $error("direction read returned data");

  sequence s_no_dir_wr;
    !(clk_en && acc.dir_wr) [*2];
  endsequence

  chk_reset_input: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) ##0 s_no_dir_wr |-> pad_q.oe == '0)
    else $error("pin driven after reset");

  chk_rmw_writeback: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_en && acc.data_wr |=> latch_q == $past(acc.wdata))
    else $error("latch did not take written value");

  chk_dir_zero_input: assert property (
    @(posedge mclk) disable iff (!rst_n)
    dir_q == GPP_DIR_RESET |-> pad_q.oe == '0)
    else $error("zero direction not input");

  // ----------------------------------------------------------------
  // multi-step checks
  // ----------------------------------------------------------------
  sequence s_two_enabled;
    clk_en ##1 clk_en;
  endsequence

  sequence s_data_write;
    clk_en && acc.data_wr;
  endsequence

  sequence s_dir_write;
    clk_en && acc.dir_wr;
  endsequence

  sequence s_data_read;
    clk_en && acc.data_rd;
  endsequence

  sequence s_dir_read_only;
    clk_en && acc.dir_rd && !acc.dir_wr && !acc.data_wr;
  endsequence

  // two enabled edges carry a pin level to the read path
  chk_pin_sync_path: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_two_enabled |=> pin_sync_q == $past(pin_in, 2))
    else $error("pin level not synchronised");

  chk_read_periph_bit: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_data_read |=>
      (rdata_q & $past(dir_q) & PERIPH_READ) ==
      ($past(periph_out) & $past(dir_q) & PERIPH_READ))
    else $error("peripheral bit read wrong");

  chk_od_out_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pad_q.out & OPEN_DRAIN) == '0)
    else $error("open-drain pin given a high level");

  // open-drain bit still pulls low when latch is zero
  chk_od_drive_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pad_q.oe & OPEN_DRAIN) == (dir_q & ~latch_q & OPEN_DRAIN))
    else $error("open-drain pin not pulling low");

  chk_pullup_follows: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_en |=> pad_q.pullup_en == ($past(pullup_ctl) & ~dir_q))
    else $error("pull-up not following control on input pin");

  chk_dir_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(clk_en && acc.dir_wr) |=> $stable(dir_q))
    else $error("direction changed without a write");

  chk_latch_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(clk_en && acc.data_wr) |=> $stable(latch_q))
    else $error("latch changed without a write");

  // read data stands until the next read
  chk_rdata_holds: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(clk_en && (acc.data_rd || acc.dir_rd)) |=> $stable(rdata_q))
    else $error("read data changed without a read");

  chk_out_follows_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_data_write |=>
      (pad_q.out & ~OPEN_DRAIN) == ($past(acc.wdata) & ~OPEN_DRAIN))
    else $error("pin level not following latch write");

  // new direction reaches the pads on the same edge that loads dir_q
  chk_oe_after_dir_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_dir_write |=>
      pad_q.oe == ($past(acc.wdata) & ~(OPEN_DRAIN & latch_q)))
    else $error("direction write not reflected on pads");

  chk_reset_outputs: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> pad_q == '0 && rdata_q == GPP_LATCH_RESET)
    else $error("outputs not quiet after reset");

  // a direction read has no side effect on the port
  chk_dir_read_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_dir_read_only |=> $stable(dir_q) && $stable(latch_q))
    else $error("direction read disturbed the port");

  // frozen clock enable leaves the pads alone
  chk_pad_freeze: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !clk_en |=> $stable(pad_q))
    else $error("pads changed while clock enable low");

endmodule
